/* File: src/wdc_pkg.sv */
// Constants, register map and carrier types for the watchdog and wake-up block.
// Assumes a single 50 MHz AHB-Lite clock domain; sub clock and port pins arrive asynchronously.
// What this block does
// R1: Sleep or idle wakes on port, interrupt, overflow
// R2: Overflow wake-up starts a watchdog reset
// R3: Power-down flag: clear on power-up/clear, set on halt
// R4: Time-out flag set on every watchdog time-out
// R5: Normal time-out full reset; asleep resets only PC, SP
// R6: Each port pin has own wake enable bit
// R7: Port wake resumes after halt instruction
// R8: Disabled or stack-full interrupt resumes, stays pending
// R9: Enabled interrupt with stack room takes vector
// R10: Flag already set before halt cannot wake
// R11: Watchdog counts sub clock, source from select register
// R12: Period select picks two-power sub-clock count
// R13: Key disables on 10101, enables on 01010, else resets
// R14: Invalid key resets after 2 to 3 sub-clock cycles
// R15: Key reset flag set by hardware, cleared by software
// R16: Key loads 01010 at power-on
// R17: Count cleared by key reset, clear instruction, halt
// R18: Power-on reset sets program counter to zero; no pulse is sent for this, the core's own reset pin covers power-on
// R19: Counter steps per sub clock, flags selected count
// R20: Flags after reset follow the reset-cause table
package wdc_pkg;
  localparam logic [7:0] WDC_WDT_CTRL_RST = 8'h53;
  localparam logic [4:0] WDC_KEY_OFF = 5'h15;
  localparam logic [4:0] WDC_KEY_ON = 5'h0a;
  localparam int WDC_KEY_LSB = 3;
  localparam int WDC_CNT_W = 18;
  localparam int WDC_PA_W = 8;
  localparam int WDC_IRQ_W = 8;
  // Key reset fires on the third sub-clock edge after the bad value
  localparam logic [1:0] WDC_KEY_DLY = 2'h3;
  localparam logic [1:0] WDC_KEY_LAST = 2'h1;
  // Time-out period exponents, one per select code
  localparam int WDC_SH_P0 = 8;
  localparam int WDC_SH_P1 = 10;
  localparam int WDC_SH_P2 = 12;
  localparam int WDC_SH_P3 = 14;
  localparam int WDC_SH_P4 = 15;
  localparam int WDC_SH_P5 = 16;
  localparam int WDC_SH_P6 = 17;
  localparam int WDC_SH_P7 = 18;
  // Register byte offsets
  localparam logic [7:0] WDC_A_WDT_CTRL = 8'h00;
  localparam logic [7:0] WDC_A_SYS_FLAGS = 8'h04;
  localparam logic [7:0] WDC_A_PA_WAKE = 8'h08;
  localparam logic [7:0] WDC_A_SUBCLK_SEL = 8'h0c;
  localparam logic [7:0] WDC_A_STATUS = 8'h10;
  localparam logic [7:0] WDC_A_CMD = 8'h14;
  // Bit positions
  localparam int WDC_B_KEYRST = 0;
  localparam int WDC_B_TO = 0;
  localparam int WDC_B_PDF = 1;
  localparam int WDC_B_ASLEEP = 2;
  localparam int WDC_B_CLRWDT = 0;
  localparam int WDC_B_HALT = 1;
  typedef enum logic [1:0] {WDC_RUN = 2'b00, WDC_SLEEP = 2'b01, WDC_RSTHOLD = 2'b11} wdc_state_t;
  typedef struct packed {
    logic full_rst;
    logic pc_sp_rst;
    logic resume;
    logic take_irq;
  } wdc_core_t;
endpackage

/* File: src/wdc_top.sv */
// Watchdog timer, key check, reset flags and sleep wake-up control.
// Assumes the core reports halt and clear-watchdog as one-cycle pulses on hclk or via the command register.
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module wdc_top import wdc_pkg::*; #(
  parameter int PA_W = WDC_PA_W,
  parameter int IRQ_W = WDC_IRQ_W
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Asynchronous sources
  input wire logic low_speed_internal_rc_clk,
  input wire logic lxt_clk,
  input wire logic [PA_W-1:0] porta_pins,
  // Core side
  input wire logic halt_instr,
  input wire logic clear_watchdog_instr,
  input wire logic [IRQ_W-1:0] irq_req,
  input wire logic [IRQ_W-1:0] irq_en,
  input wire logic stack_full,
  output wdc_core_t core_ctl,
  output logic asleep
);
  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers: first stage read only by second
  logic [2:0] low_speed_internal_rc_s_ff, lxt_s_ff, nxt_low_speed_internal_rc_s, nxt_lxt_s;
  logic [PA_W-1:0] pa_s1_ff, pa_s2_ff, pa_d_ff, nxt_pa_s1, nxt_pa_s2, nxt_pa_d;

  // Sub-clock sources: two stages, then one more for the edge
  always_comb begin
    nxt_low_speed_internal_rc_s = {low_speed_internal_rc_s_ff[1:0], low_speed_internal_rc_clk};
    nxt_lxt_s = {lxt_s_ff[1:0], lxt_clk};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_speed_internal_rc_s_ff <= 3'h0;
      lxt_s_ff <= 3'h0;
    end else begin
      low_speed_internal_rc_s_ff <= nxt_low_speed_internal_rc_s;
      lxt_s_ff <= nxt_lxt_s;
    end
  end

  // Pins reset high like their idle level, so no false edge follows reset
  always_comb begin
    nxt_pa_s1 = porta_pins;
    nxt_pa_s2 = pa_s1_ff;
    nxt_pa_d = pa_s2_ff;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pa_s1_ff <= '1;
      pa_s2_ff <= '1;
      pa_d_ff <= '1;
    end else begin
      pa_s1_ff <= nxt_pa_s1;
      pa_s2_ff <= nxt_pa_s2;
      pa_d_ff <= nxt_pa_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [7:0] wdt_ctrl_ff, nxt_wdt_ctrl;
  logic key_flag_ff, nxt_key_flag;
  logic [PA_W-1:0] porta_wake_enable_ff, nxt_porta_wake_enable;
  logic sub_clock_select_reg_ff, nxt_sub_clock_select_reg;
  logic timeout_flag_ff, nxt_timeout_flag;
  logic power_down_flag_ff, nxt_power_down_flag;
  logic [WDC_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [1:0] keydly_ff, nxt_keydly;
  logic key_bad_ff, nxt_key_bad;
  logic [IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
  logic [IRQ_W-1:0] pend_ff, nxt_pend;
  wdc_state_t state_ff, nxt_state;
  wdc_core_t ctl_ff, nxt_ctl;
  logic ap_wr_ff, ap_rd_ff, nxt_ap_wr, nxt_ap_rd;
  logic [7:0] ap_addr_ff, nxt_ap_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;

  logic [4:0] wdt_enable_key;
  logic [2:0] timeout_period_select;
  logic sub_tick, wdt_on, timeout, key_valid, porta_fall, irq_wake, do_clr, do_halt;
  logic [WDC_CNT_W-1:0] period_m1;

  assign wdt_enable_key = wdt_ctrl_ff[7:WDC_KEY_LSB];
  assign timeout_period_select = wdt_ctrl_ff[WDC_KEY_LSB-1:0];
  // Sub clock rising edge from the selected low-speed source [R11]
  assign sub_tick = sub_clock_select_reg_ff ? (lxt_s_ff[1] & ~lxt_s_ff[2]) : (low_speed_internal_rc_s_ff[1] & ~low_speed_internal_rc_s_ff[2]);
  assign key_valid = (wdt_enable_key == WDC_KEY_OFF) || (wdt_enable_key == WDC_KEY_ON); // [R13]
  assign wdt_on = (wdt_enable_key == WDC_KEY_ON); // [R13]
  // Sleep counts only while the sub clock runs; stopped sources simply never tick
  assign timeout = wdt_on && sub_tick && (cnt_ff == period_m1); // [R19]
  assign porta_fall = |(pa_d_ff & ~pa_s2_ff & porta_wake_enable_ff); // [R6]
  // Only requests raised after halt may wake [R10]
  assign irq_wake = |(irq_req & ~irq_mask_ff);

  always_comb begin
    period_m1 = '0;
    case (timeout_period_select) // [R12]
      3'h0: period_m1 = WDC_CNT_W'((1 << WDC_SH_P0) - 1);
      3'h1: period_m1 = WDC_CNT_W'((1 << WDC_SH_P1) - 1);
      3'h2: period_m1 = WDC_CNT_W'((1 << WDC_SH_P2) - 1);
      3'h3: period_m1 = WDC_CNT_W'((1 << WDC_SH_P3) - 1);
      3'h4: period_m1 = WDC_CNT_W'((1 << WDC_SH_P4) - 1);
      3'h5: period_m1 = WDC_CNT_W'((1 << WDC_SH_P5) - 1);
      3'h6: period_m1 = WDC_CNT_W'((1 << WDC_SH_P6) - 1);
      default: period_m1 = WDC_CNT_W'((1 << WDC_SH_P7) - 1);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY
  logic bus_wr;
  assign bus_wr = ap_wr_ff;
  assign do_clr = clear_watchdog_instr || (bus_wr && ap_addr_ff == WDC_A_CMD && hwdata[WDC_B_CLRWDT]);
  assign do_halt = halt_instr || (bus_wr && ap_addr_ff == WDC_A_CMD && hwdata[WDC_B_HALT]);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_comb begin
    nxt_ap_wr = hsel && hready && htrans[1] && hwrite;
    nxt_ap_rd = hsel && hready && htrans[1] && !hwrite;
    nxt_ap_addr = haddr[7:0];
    nxt_hrdata = 32'h0;
    if (nxt_ap_rd) begin
      case (nxt_ap_addr)
        WDC_A_WDT_CTRL: nxt_hrdata = {24'h0, wdt_ctrl_ff};
        WDC_A_SYS_FLAGS: nxt_hrdata = {31'h0, key_flag_ff};
        WDC_A_PA_WAKE: nxt_hrdata = 32'(porta_wake_enable_ff);
        WDC_A_SUBCLK_SEL: nxt_hrdata = {31'h0, sub_clock_select_reg_ff};
        WDC_A_STATUS: nxt_hrdata = {29'h0, state_ff == WDC_SLEEP, power_down_flag_ff, timeout_flag_ff};
        default: nxt_hrdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded events shared by the state groups
  logic wr_ctrl, wr_flags, wr_pawe, wr_subsel;
  logic key_rst, run_tmo, halt_go, slp_tmo, irq_go, irq_vec, pin_go, pend_srv;

  assign wr_ctrl = bus_wr && (ap_addr_ff == WDC_A_WDT_CTRL);
  assign wr_flags = bus_wr && (ap_addr_ff == WDC_A_SYS_FLAGS);
  assign wr_pawe = bus_wr && (ap_addr_ff == WDC_A_PA_WAKE);
  assign wr_subsel = bus_wr && (ap_addr_ff == WDC_A_SUBCLK_SEL);
  // Invalid key: reset on the third sub-clock edge, 2 to 3 periods late [R14]
  assign key_rst = key_bad_ff && sub_tick && (keydly_ff == WDC_KEY_LAST);
  // Watchdog beats a halt or a wake-up that lands in the same cycle [R2]
  assign run_tmo = (state_ff == WDC_RUN) && timeout;
  assign halt_go = (state_ff == WDC_RUN) && !timeout && do_halt;
  assign slp_tmo = (state_ff == WDC_SLEEP) && timeout; // [R1]
  // Interrupt wake has priority over a port wake
  assign irq_go = (state_ff == WDC_SLEEP) && !timeout && irq_wake; // [R1]
  assign irq_vec = irq_go && |(irq_req & ~irq_mask_ff & irq_en) && !stack_full; // [R9]
  assign pin_go = (state_ff == WDC_SLEEP) && !timeout && !irq_wake && porta_fall; // [R1] [R7]
  // Held requests are served once enabled with stack room [R8]
  assign pend_srv = (state_ff == WDC_RUN) && |(pend_ff & irq_en) && !stack_full;

  ////////////////////////////////////////////////////////////////////////////
  // Bus pipeline registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_ff <= 1'b0;
      ap_rd_ff <= 1'b0;
      ap_addr_ff <= 8'h0;
      hrdata_ff <= 32'h0;
    end else begin
      ap_wr_ff <= nxt_ap_wr;
      ap_rd_ff <= nxt_ap_rd;
      ap_addr_ff <= nxt_ap_addr;
      hrdata_ff <= nxt_hrdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_comb begin
    nxt_wdt_ctrl = wdt_ctrl_ff;
    nxt_key_flag = key_flag_ff;
    nxt_porta_wake_enable = porta_wake_enable_ff;
    nxt_sub_clock_select_reg = sub_clock_select_reg_ff;
    if (wr_ctrl) begin
      nxt_wdt_ctrl = hwdata[7:0];
    end
    // Software may only clear the key reset flag [R15]
    if (wr_flags && !hwdata[WDC_B_KEYRST]) begin
      nxt_key_flag = 1'b0;
    end
    if (wr_pawe) begin
      nxt_porta_wake_enable = hwdata[PA_W-1:0]; // [R6]
    end
    if (wr_subsel) begin
      nxt_sub_clock_select_reg = hwdata[0]; // [R11]
    end
    // Key reset restores the power-on value; a clear in the same cycle loses
    if (key_rst) begin
      nxt_wdt_ctrl = WDC_WDT_CTRL_RST; // [R16]
      nxt_key_flag = 1'b1; // [R14] [R15]
    end
  end

  // Power-on: key enabled, flag clear, no pins armed, internal RC selected [R16]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_ctrl_ff <= WDC_WDT_CTRL_RST;
      key_flag_ff <= 1'b0;
      porta_wake_enable_ff <= '0;
      sub_clock_select_reg_ff <= 1'b0;
    end else begin
      wdt_ctrl_ff <= nxt_wdt_ctrl;
      key_flag_ff <= nxt_key_flag;
      porta_wake_enable_ff <= nxt_porta_wake_enable;
      sub_clock_select_reg_ff <= nxt_sub_clock_select_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time-out and power-down flags
  always_comb begin
    nxt_timeout_flag = timeout_flag_ff;
    nxt_power_down_flag = power_down_flag_ff;
    // Clearing the watchdog also clears both flags
    if (do_clr) begin
      nxt_timeout_flag = 1'b0;
      nxt_power_down_flag = 1'b0; // [R3]
    end
    if (halt_go) begin
      nxt_timeout_flag = 1'b0;
      nxt_power_down_flag = 1'b1; // [R3]
    end
    // Asleep the power-down flag stays set, so both read 1 [R20]
    if (run_tmo || slp_tmo) begin
      nxt_timeout_flag = 1'b1; // [R4]
    end
  end

  // Power-on clears both flags [R20]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timeout_flag_ff <= 1'b0;
      power_down_flag_ff <= 1'b0;
    end else begin
      timeout_flag_ff <= nxt_timeout_flag;
      power_down_flag_ff <= nxt_power_down_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog counter and key check
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_keydly = keydly_ff;
    nxt_key_bad = key_bad_ff;
    if (wdt_on && sub_tick) begin
      nxt_cnt = WDC_CNT_W'(cnt_ff + 1'b1); // [R19]
    end
    if (do_clr || key_rst || halt_go || run_tmo || slp_tmo) begin
      nxt_cnt = '0; // [R17]
    end
    // A bad key arms the delay once; writing a good key late does not cancel it [R13]
    if (!key_valid && !key_bad_ff) begin
      nxt_key_bad = 1'b1;
      nxt_keydly = WDC_KEY_DLY;
    end else if (key_bad_ff && sub_tick) begin
      nxt_keydly = 2'(keydly_ff - 1'b1);
      if (key_rst) begin
        nxt_key_bad = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= '0;
      keydly_ff <= 2'h0;
      key_bad_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      keydly_ff <= nxt_keydly;
      key_bad_ff <= nxt_key_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep state, interrupt masking and pending requests
  always_comb begin
    nxt_state = state_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_pend = pend_ff;
    case (state_ff)
      WDC_RUN: begin
        if (halt_go) begin
          // Only requests raised after halt may wake [R10]
          nxt_irq_mask = irq_req;
          nxt_state = WDC_SLEEP;
        end
        if (pend_srv) begin
          nxt_pend = pend_ff & ~irq_en; // [R8]
        end
      end
      WDC_SLEEP: begin
        if (irq_go && !irq_vec) begin
          nxt_pend = pend_ff | (irq_req & ~irq_mask_ff); // [R8]
        end
        if (slp_tmo || irq_go || pin_go) begin
          nxt_state = WDC_RUN; // [R1]
        end
      end
      default: nxt_state = WDC_RUN;
    endcase
    // A full reset never leaves the core asleep
    if (key_rst) begin
      nxt_state = WDC_RUN;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_ff <= '0;
      pend_ff <= '0;
      state_ff <= WDC_RUN;
    end else begin
      irq_mask_ff <= nxt_irq_mask;
      pend_ff <= nxt_pend;
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core commands, one-cycle pulses
  // The core's own reset pin covers power-on, so no pulse follows it [R18]
  always_comb begin
    nxt_ctl = '0;
    if (run_tmo || key_rst) begin
      nxt_ctl.full_rst = 1'b1; // [R5] [R13]
    end
    // A key reset outranks the sleeping time-out
    if (slp_tmo && !key_rst) begin
      nxt_ctl.pc_sp_rst = 1'b1; // [R2] [R5]
    end
    if ((irq_go && !irq_vec) || pin_go) begin
      nxt_ctl.resume = 1'b1; // [R7] [R8]
    end
    if (irq_vec || pend_srv) begin
      nxt_ctl.take_irq = 1'b1; // [R8] [R9]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_ff <= '0;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  assign core_ctl = ctl_ff;
  assign asleep = (state_ff == WDC_SLEEP);
endmodule // wdc_top

/* File: verif/wdc_properties.sv */
// Port checker for wdc_top.
// Assumes one hclk domain and a bind below.
`timescale 1ns/1ps
module wdc_properties import wdc_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Core
  input wire logic halt_instr,
  input wire logic stack_full,
  input wire wdc_core_t core_ctl,
  input wire logic asleep
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_halt;
    halt_instr && !asleep;
  endsequence
  sequence s_wake;
    core_ctl.resume || core_ctl.take_irq;
  endsequence
  AST_SLEEP: assert property (s_halt |=> asleep) else $error("no sleep");
  AST_PCSP: assert property (core_ctl.pc_sp_rst |-> $past(asleep) && !core_ctl.full_rst)
    else $error("pc_sp awake");
  AST_RESUME: assert property (core_ctl.resume |-> $past(asleep)) else $error("resume awake");
  AST_VEC: assert property (core_ctl.take_irq |-> !$past(stack_full)) else $error("vector full");
  AST_FULL: assert property (core_ctl.full_rst |=> !core_ctl.full_rst) else $error("long rst");
  AST_LEAVE: assert property (s_wake |-> ##[0:2] !asleep) else $error("still asleep");
  AST_BUS: assert property (hreadyout && !hresp) else $error("bus not okay");
  AST_RDZ: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
    else $error("stray rdata");
endmodule // wdc_properties
bind wdc_top wdc_properties i_wdc_properties (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .halt_instr(halt_instr), .stack_full(stack_full), .core_ctl(core_ctl), .asleep(asleep));

/* File: verif/wdc_top_tb.sv */
// Directed bench for wdc_top.
// Assumes the checker binds itself.
`timescale 1ns/1ps
module wdc_top_tb import wdc_pkg::*;;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, halt_instr = 0, stack_full = 0, low_speed_internal_rc_clk = 0;
  logic clear_watchdog_instr = 0;
  logic [1:0] htrans = 2'h0, lcnt = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [7:0] porta_pins = 8'hff, irq_req = 8'h0, irq_en = 8'h0;
  logic hreadyout, hresp, asleep, hit;
  wdc_core_t core_ctl;
  int errors = 0, num_checks = 0;
  always #10 hclk = ~hclk;
  // Sub clock at a quarter of hclk keeps long periods short
  always @(posedge hclk) begin
    lcnt <= lcnt + 2'h1;
    low_speed_internal_rc_clk <= lcnt[1];
  end
  wdc_top i_wdc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .low_speed_internal_rc_clk(low_speed_internal_rc_clk), .lxt_clk(1'b0), .porta_pins(porta_pins),
    .halt_instr(halt_instr), .clear_watchdog_instr(clear_watchdog_instr), .irq_req(irq_req), .irq_en(irq_en),
    .stack_full(stack_full), .core_ctl(core_ctl), .asleep(asleep));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic waitc(input int b, input int n);
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++) begin
      @(posedge hclk);
      hit = (core_ctl[b] === 1'b1);
    end
  endtask
  task automatic halt();
    halt_instr <= 1'b1;
    @(posedge hclk);
    halt_instr <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #800000;
    errors++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc("ctrl", 8'h00, 32'h53);
    rc("status", 8'h10, 32'h0);
    rc("flags", 8'h04, 32'h0);
    rc("unmapped", 8'h20, 32'h0);
    $display("reset test done");
    // Periods 2^8 and 2^10 sub edges, four hclk each
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 8'h00, {24'h0, WDC_KEY_ON, 3'(k)});
      bus(1'b1, 8'h14, 32'h1);
      waitc(3, (4 << (8 + 2 * k)) - 40);
      chk("early rst", 32'h0, 32'(hit));
      waitc(3, 80);
      chk("full rst", 32'h1, 32'(hit));
      rc("to flag", 8'h10, 32'h1);
    end
    $display("timeout test done");
    bus(1'b1, 8'h00, 32'h53);
    bus(1'b1, 8'h08, 32'h4);
    halt();
    rc("halt status", 8'h10, 32'h6);
    porta_pins <= 8'hf7;
    waitc(1, 20);
    chk("masked pin", 32'h0, 32'(hit));
    porta_pins <= 8'hf3;
    waitc(1, 20);
    chk("pin wake", 32'h1, 32'(hit));
    porta_pins <= 8'hff;
    stack_full <= 1'b1;
    irq_en <= 8'h01;
    halt();
    irq_req <= 8'h01;
    waitc(1, 20);
    chk("full stack", 32'h1, 32'(hit));
    stack_full <= 1'b0;
    waitc(0, 20);
    chk("pending", 32'h1, 32'(hit));
    irq_req <= 8'h00;
    @(posedge hclk);
    halt();
    irq_req <= 8'h01;
    waitc(0, 20);
    chk("vector", 32'h1, 32'(hit));
    irq_req <= 8'h02;
    irq_en <= 8'h02;
    @(posedge hclk);
    halt();
    waitc(0, 30);
    chk("stale flag", 32'h0, 32'(hit));
    porta_pins <= 8'hfb;
    waitc(1, 20);
    chk("pin wake2", 32'h1, 32'(hit));
    porta_pins <= 8'hff;
    irq_req <= 8'h00;
    bus(1'b1, 8'h00, 32'h50);
    halt();
    waitc(2, 1100);
    chk("sleep tmo", 32'h1, 32'(hit));
    bus(1'b0, 8'h10, 32'h0);
    chk("sleep flags", 32'h3, rd & 32'h3);
    clear_watchdog_instr <= 1'b1;
    @(posedge hclk);
    clear_watchdog_instr <= 1'b0;
    rc("clr flags", 8'h10, 32'h0);
    $display("sleep test done");
    bus(1'b1, 8'h00, 32'hf8);
    waitc(3, 8);
    chk("key early", 32'h0, 32'(hit));
    waitc(3, 20);
    chk("key rst", 32'h1, 32'(hit));
    rc("ctrl key", 8'h00, 32'h53);
    rc("key flag", 8'h04, 32'h1);
    bus(1'b1, 8'h04, 32'h1);
    rc("flag w1", 8'h04, 32'h1);
    bus(1'b1, 8'h04, 32'h0);
    rc("flag w0", 8'h04, 32'h0);
    bus(1'b1, 8'h00, 32'ha8);
    waitc(3, 1200);
    chk("disabled", 32'h0, 32'(hit));
    // Crystal input is held still, so its count must not move
    bus(1'b1, 8'h0c, 32'h1);
    bus(1'b1, 8'h00, 32'h50);
    bus(1'b1, 8'h14, 32'h1);
    waitc(3, 1200);
    chk("crystal", 32'h0, 32'(hit));
    $display("key test done");
    final_report();
  end
endmodule // wdc_top_tb
